// file: hdl/trm_pkg.sv
// Constants for the trigger routing matrix: line counts, source select codes, clock figures.
// Assumes one 25 MHz system clock and the backplane 10 MHz reference arriving on a pin.
package trm_pkg;

  // Line counts per group
  localparam int unsigned NUM_FP = 3;
  localparam int unsigned NUM_STAR = 13;
  localparam int unsigned NUM_BUS = 8;

  // Width of a per-line source select code
  localparam int unsigned SEL_W = 5;

  // Internal sources sit just above the last line index
  localparam int unsigned SEL_TIME_OFS = 0;
  localparam int unsigned SEL_CLK_OFS = 1;
  localparam int unsigned SEL_GND_OFS = 2;
  localparam int unsigned NUM_INTERNAL_SRC = 3;

  // System clock and sync clock figures
  localparam int unsigned REF_CLK_PERIOD_NS = 40;
  localparam int unsigned REF_CLK_MHZ = 1000 / REF_CLK_PERIOD_NS;
  localparam int unsigned SYNC_CLK_MHZ = 10;

  // Synchroniser depth on every pin input
  localparam int unsigned SYNC_STAGES = 2;

endpackage : trm_pkg

// file: hdl/trm_route_slot.sv
// One destination line of the trigger matrix: source mux, sync register, drive enable.
// Assumes lines arrive both raw and already synchronised, plus a one-cycle sync clock edge strobe.
`timescale 1ns/100ps

module trm_route_slot #(
  parameter int unsigned NUM_LINES = trm_pkg::NUM_FP + trm_pkg::NUM_STAR + trm_pkg::NUM_BUS,
  parameter int unsigned SELF = 0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic sync_en_i,
  input wire logic [trm_pkg::SEL_W-1:0] src_sel_i,
  input wire logic [NUM_LINES-1:0] line_async_i,
  input wire logic [NUM_LINES-1:0] line_sync_i,
  input wire logic time_event_i,
  input wire logic clk10_i,
  input wire logic clk10_rise_i,
  output logic out_o,
  output logic oe_o
);

  localparam logic [trm_pkg::SEL_W-1:0] SEL_TIME = trm_pkg::SEL_W'(NUM_LINES + trm_pkg::SEL_TIME_OFS);
  localparam logic [trm_pkg::SEL_W-1:0] SEL_CLK = trm_pkg::SEL_W'(NUM_LINES + trm_pkg::SEL_CLK_OFS);
  localparam logic [trm_pkg::SEL_W-1:0] SEL_GND = trm_pkg::SEL_W'(NUM_LINES + trm_pkg::SEL_GND_OFS);
  localparam logic [trm_pkg::SEL_W-1:0] SEL_SELF = trm_pkg::SEL_W'(SELF);

  typedef struct packed {
    logic sync_out;
  } trm_slot_state_t;

  trm_slot_state_t state_q;
  trm_slot_state_t state_d;
  logic src_is_line;
  logic sync_mode;
  logic async_val;
  logic sel_sync_bit;

  // Own line as source would loop pad back to pad; treated as ground
  assign src_is_line = (src_sel_i < SEL_TIME) && (src_sel_i != SEL_SELF);
  assign sync_mode = sync_en_i && src_is_line;
  assign sel_sync_bit = src_is_line ? line_sync_i[src_sel_i] : 1'b0;

  always_comb begin
    state_d = state_q;
    async_val = 1'b0;
    if (src_is_line) begin
      async_val = line_async_i[src_sel_i];
    end else if (src_sel_i == SEL_TIME) begin
      async_val = time_event_i;
    end else if (src_sel_i == SEL_CLK) begin
      async_val = clk10_i;
    end
    if (!sync_mode) begin
      state_d.sync_out = 1'b0;
    end else if (clk10_rise_i) begin
      state_d.sync_out = sel_sync_bit;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign out_o = sync_mode ? state_q.sync_out : async_val;
  assign oe_o = enable_i;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_async_pass;
    enable_i && !sync_en_i && src_is_line |-> out_o == line_async_i[src_sel_i];
  endproperty
  a_async_pass: assert property (p_async_pass) else $error("async route not passing source");

  property p_sync_hold;
    sync_mode && !clk10_rise_i ##1 sync_mode && $stable(src_sel_i) |-> $stable(out_o);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync output moved between clock edges");

  property p_sync_take;
    sync_mode && clk10_rise_i ##1 sync_mode |-> out_o == $past(sel_sync_bit);
  endproperty
  a_sync_take: assert property (p_sync_take) else $error("sync output missed source at edge");

  property p_time_no_sync;
    src_sel_i == SEL_TIME |-> out_o == time_event_i;
  endproperty
  a_time_no_sync: assert property (p_time_no_sync) else $error("time event route was clocked");

  property p_ground;
    src_sel_i == SEL_GND |-> !out_o;
  endproperty
  a_ground: assert property (p_ground) else $error("ground source not low");

  property p_clk_src;
    src_sel_i == SEL_CLK |-> out_o == clk10_i;
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source not passed");

  c_sync_take: cover property (sync_mode && clk10_rise_i && sel_sync_bit ##1 out_o);
  c_async_rise: cover property (enable_i && !sync_mode && src_is_line && !out_o ##1 out_o);

endmodule : trm_route_slot

// file: hdl/trm_matrix.sv
// Trigger routing crossbar over front-panel pins, star lines and trigger bus lines.
// Assumes configuration inputs come from logic on ref_clk_i; every pin and the
// backplane 10 MHz clock arrive from outside and are synchronised here.
`timescale 1ns/100ps

module trm_matrix #(
  parameter int unsigned NUM_FP = trm_pkg::NUM_FP,
  parameter int unsigned NUM_STAR = trm_pkg::NUM_STAR,
  parameter int unsigned NUM_BUS = trm_pkg::NUM_BUS
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic pxi_clk10_i,
  input wire logic time_event_i,
  input wire logic [NUM_FP-1:0] fp_trig_in_i,
  output logic [NUM_FP-1:0] fp_trig_out_o,
  output logic [NUM_FP-1:0] fp_trig_oe_o,
  input wire logic [NUM_STAR-1:0] star_trig_in_i,
  output logic [NUM_STAR-1:0] star_trig_out_o,
  output logic [NUM_STAR-1:0] star_trig_oe_o,
  input wire logic [NUM_BUS-1:0] bus_trig_in_i,
  output logic [NUM_BUS-1:0] bus_trig_out_o,
  output logic [NUM_BUS-1:0] bus_trig_oe_o,
  input wire logic [NUM_FP+NUM_STAR+NUM_BUS-1:0] route_enable_i,
  input wire logic [NUM_FP+NUM_STAR+NUM_BUS-1:0] route_sync_i,
  input wire logic [NUM_FP+NUM_STAR+NUM_BUS-1:0][trm_pkg::SEL_W-1:0] route_src_i
);

  localparam int unsigned NUM_LINES = NUM_FP + NUM_STAR + NUM_BUS;
  localparam int unsigned STAR_BASE = NUM_FP;
  localparam int unsigned BUS_BASE = NUM_FP + NUM_STAR;

  // Strobe spacing in system clock cycles, for the checks below
  localparam int RISE_GAP_MIN = trm_pkg::REF_CLK_MHZ / trm_pkg::SYNC_CLK_MHZ;
  localparam int RISE_GAP_MAX = (trm_pkg::REF_CLK_MHZ + trm_pkg::SYNC_CLK_MHZ - 1) / trm_pkg::SYNC_CLK_MHZ;

  // Select codes must fit lines plus the three internal sources
  if (NUM_FP < 1 || NUM_STAR < 1 || NUM_BUS < 1 ||
      NUM_LINES + trm_pkg::NUM_INTERNAL_SRC > (1 << trm_pkg::SEL_W)) begin : g_bad_params
    $error("trm_matrix: line counts do not fit the source select code");
  end

  // Edge strobe needs the system clock above twice the sync clock
  if (trm_pkg::REF_CLK_MHZ <= 2 * trm_pkg::SYNC_CLK_MHZ) begin : g_bad_clock
    $error("trm_matrix: system clock too slow to sample the sync clock");
  end

  typedef struct packed {
    logic clk10_ff1;
    logic clk10_ff2;
    logic clk10_ff3;
    logic [trm_pkg::SYNC_STAGES:0] prime;
    logic [NUM_LINES-1:0] line_ff1;
    logic [NUM_LINES-1:0] line_ff2;
  } trm_state_t;

  trm_state_t state_q;
  trm_state_t state_d;
  logic [trm_pkg::SYNC_STAGES-1:0] rst_sync_q;
  logic rst_n;
  logic clk10_rise;
  logic [NUM_LINES-1:0] line_in;
  logic [NUM_LINES-1:0] line_out;
  logic [NUM_LINES-1:0] line_oe;

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= {rst_sync_q[trm_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[trm_pkg::SYNC_STAGES-1];

  // Line order: front panel, then star, then bus
  assign line_in = {bus_trig_in_i, star_trig_in_i, fp_trig_in_i};

  always_comb begin
    state_d = state_q;
    state_d.clk10_ff1 = pxi_clk10_i;
    state_d.clk10_ff2 = state_q.clk10_ff1;
    state_d.clk10_ff3 = state_q.clk10_ff2;
    // Strobe held off until the clock chain holds real samples
    state_d.prime = {state_q.prime[trm_pkg::SYNC_STAGES-1:0], 1'b1};
    state_d.line_ff1 = line_in;
    state_d.line_ff2 = state_q.line_ff1;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // One shared edge strobe keeps all sync routes in the same cycle
  // No false edge from the cleared chain right after reset
  assign clk10_rise = state_q.clk10_ff2 && !state_q.clk10_ff3 && state_q.prime[trm_pkg::SYNC_STAGES];

  for (genvar i = 0; i < NUM_LINES; i++) begin : g_slot
    // Each destination owns its select, mode and enable
    trm_route_slot #(
      .NUM_LINES(NUM_LINES),
      .SELF(i)
    ) u_slot (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .enable_i(route_enable_i[i] && rst_n),
      .sync_en_i(route_sync_i[i]),
      .src_sel_i(route_src_i[i]),
      .line_async_i(line_in),
      .line_sync_i(state_q.line_ff2),
      .time_event_i(time_event_i),
      .clk10_i(pxi_clk10_i),
      .clk10_rise_i(clk10_rise),
      .out_o(line_out[i]),
      .oe_o(line_oe[i])
    );
  end

  // Only the three line kinds have drivers
  assign fp_trig_out_o = line_out[NUM_FP-1:0];
  assign fp_trig_oe_o = line_oe[NUM_FP-1:0];
  assign star_trig_out_o = line_out[BUS_BASE-1:STAR_BASE];
  assign star_trig_oe_o = line_oe[BUS_BASE-1:STAR_BASE];
  assign bus_trig_out_o = line_out[NUM_LINES-1:BUS_BASE];
  assign bus_trig_oe_o = line_oe[NUM_LINES-1:BUS_BASE];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  property p_rise_pulse;
    clk10_rise |=> !clk10_rise;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse) else $error("sync edge strobe longer than one cycle");

  property p_line_latency;
    rst_n ##2 1'b1 |-> state_q.line_ff2 == $past(line_in, 2);
  endproperty
  a_line_latency: assert property (p_line_latency) else $error("line sync latency not two cycles");

  property p_rise_follows_pin;
    clk10_rise |-> $past(pxi_clk10_i, 2) && !$past(pxi_clk10_i, 3);
  endproperty
  a_rise_follows_pin: assert property (p_rise_follows_pin) else $error("sync edge strobe not from clock pin");

  // Strobes come once per sync clock period, never skipped
  property p_rise_spacing;
    clk10_rise |-> ##[RISE_GAP_MIN:RISE_GAP_MAX] clk10_rise;
  endproperty
  a_rise_spacing: assert property (p_rise_spacing) else $error("sync edge strobe spacing off");

  // Nothing driven while the internal reset stands
  property p_reset_quiet;
    @(posedge ref_clk_i) disable iff (1'b0) !rst_n |-> line_oe == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("line driven during reset");

  for (genvar k = 0; k < NUM_LINES; k++) begin : g_chk
    property p_undriven;
      !route_enable_i[k] |-> !line_oe[k];
    endproperty
    a_undriven: assert property (p_undriven) else $error("line driven without a route");

    property p_driven;
      route_enable_i[k] |-> line_oe[k];
    endproperty
    a_driven: assert property (p_driven) else $error("routed line not driven");

    property p_own_line;
      route_src_i[k] == k |-> !line_out[k];
    endproperty
    a_own_line: assert property (p_own_line) else $error("own line looped back");

    property p_time_line;
      route_src_i[k] == NUM_LINES + trm_pkg::SEL_TIME_OFS |-> line_out[k] == time_event_i;
    endproperty
    a_time_line: assert property (p_time_line) else $error("time event not passed straight");

    property p_gnd_line;
      route_src_i[k] > NUM_LINES + trm_pkg::SEL_CLK_OFS |-> !line_out[k];
    endproperty
    a_gnd_line: assert property (p_gnd_line) else $error("ground code not low");

    property p_async_line;
      route_enable_i[k] && !route_sync_i[k] && route_src_i[k] < NUM_LINES && route_src_i[k] != k
        |-> line_out[k] == line_in[route_src_i[k]];
    endproperty
    a_async_line: assert property (p_async_line) else $error("async route lost its source");

    property p_sync_aligned;
      $changed(line_out[k]) && route_sync_i[k] && $stable(route_sync_i[k])
        && $stable(route_src_i[k]) && route_src_i[k] < NUM_LINES |-> $past(clk10_rise);
    endproperty
    a_sync_aligned: assert property (p_sync_aligned) else $error("sync output changed off clock edge");

    property p_sync_line;
      route_sync_i[k] && route_src_i[k] < NUM_LINES && route_src_i[k] != k && clk10_rise
        ##1 route_sync_i[k] && $stable(route_src_i[k])
        |-> line_out[k] == $past(state_q.line_ff2[route_src_i[k]]);
    endproperty
    a_sync_line: assert property (p_sync_line) else $error("sync route missed its synchronised source");

    // Neighbouring sync routes off one source switch together
    localparam int unsigned NXT = (k + 1) % NUM_LINES;
    property p_sync_pair;
      route_sync_i[k] && route_sync_i[NXT] && route_src_i[k] == route_src_i[NXT] && route_src_i[k] < NUM_LINES
        && route_src_i[k] != k && route_src_i[k] != NXT && clk10_rise
        ##1 route_sync_i[k] && route_sync_i[NXT] && $stable(route_src_i[k]) && $stable(route_src_i[NXT])
        |-> line_out[k] == line_out[NXT];
    endproperty
    a_sync_pair: assert property (p_sync_pair) else $error("sync routes from one source split apart");
  end

  c_two_sync: cover property (clk10_rise && route_sync_i[BUS_BASE-1] && route_sync_i[BUS_BASE]
    && route_src_i[BUS_BASE-1] == route_src_i[BUS_BASE]);
  c_star_drive: cover property (star_trig_oe_o[0] ##1 !star_trig_oe_o[0]);
  c_clk_rise: cover property (clk10_rise ##2 clk10_rise);

endmodule : trm_matrix

// file: sim/trm_far_end.sv
// Far-side model: other modules and instruments on the trigger lines.
// Assumes line packing front panel, star, bus; bench picks what the far end drives.
`timescale 1ns/100ps

module trm_far_end (
  input wire logic clk_i,
  input wire logic [23:0] drv_en_i,
  input wire logic [23:0] drv_val_i,
  input wire logic [23:0] dev_out_i,
  input wire logic [23:0] dev_oe_i,
  output logic [23:0] wire_o
);
  logic tog_q = 1'b0;
  always @(posedge clk_i) tog_q <= ~tog_q;
  // Released lines wander, never hold a stale level
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      wire_o[i] = dev_oe_i[i] ? dev_out_i[i] : drv_en_i[i] ? drv_val_i[i] : tog_q ^ i[0];
    end
  end
endmodule : trm_far_end

// file: sim/test_trm_matrix.sv
// Testbench for the trigger routing matrix: async, internal and sync routes.
// Assumes the far-end model on every line and a free-running 10 MHz backplane clock.
`timescale 1ns/100ps

module test_trm_matrix;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pxi_clk10_i = 1'b0;
  logic time_event_i = 1'b0;
  logic [23:0] en = '0;
  logic [23:0] syn = '0;
  logic [23:0] drv_en = '0;
  logic [23:0] drv_val = '0;
  logic [23:0][4:0] src = '0;
  wire [23:0] outs;
  wire [23:0] oes;
  wire [23:0] lines;
  int err_count = 0;
  int comparisons = 0;

  always #20 ref_clk_i = ~ref_clk_i;
  // Off the system clock edges so pin sampling never races
  initial #9 forever #50 pxi_clk10_i = ~pxi_clk10_i;

  trm_matrix dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .pxi_clk10_i(pxi_clk10_i),
    .time_event_i(time_event_i), .fp_trig_in_i(lines[2:0]), .fp_trig_out_o(outs[2:0]),
    .fp_trig_oe_o(oes[2:0]), .star_trig_in_i(lines[15:3]), .star_trig_out_o(outs[15:3]),
    .star_trig_oe_o(oes[15:3]), .bus_trig_in_i(lines[23:16]), .bus_trig_out_o(outs[23:16]),
    .bus_trig_oe_o(oes[23:16]), .route_enable_i(en), .route_sync_i(syn), .route_src_i(src));

  trm_far_end far (.clk_i(ref_clk_i), .drv_en_i(drv_en), .drv_val_i(drv_val),
    .dev_out_i(outs), .dev_oe_i(oes), .wire_o(lines));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : tick

  task automatic complete_run;
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run

  // Half the lines are outputs, each fed from a line of the other half
  task automatic t_async(input logic odd);
    logic [23:0] mask;
    logic [23:0] exp;
    logic [23:0] pat [4];
    mask = odd ? 24'haa_aaaa : 24'h55_5555;
    pat = '{24'h00_0000, 24'hff_ffff, 24'h5a_c3a5, 24'ha5_3c5a};
    tick(1);
    for (int i = 0; i < 24; i++) src[i] = 5'((i + 5) % 24);
    syn = '0;
    en = mask;
    drv_en = ~mask;
    for (int p = 0; p < 4; p++) begin
      tick(1);
      drv_val = pat[p];
      #1;
      for (int i = 0; i < 24; i++) exp[i] = mask[i] & drv_val[src[i]];
      check(outs & mask, exp);
      check(oes, mask);
    end
  endtask : t_async

  // Time event, clock, ground and own line, sync bit set
  task automatic t_int;
    tick(1);
    en = 24'h00_0001;
    syn = 24'h00_0001;
    drv_en = 24'hff_fffe;
    drv_val = 24'hff_ffff;
    src[0] = 5'd24;
    for (int v = 0; v < 2; v++) begin
      tick(1);
      time_event_i = v[0];
      #1;
      check(24'(outs[0]), 24'(v[0]));
    end
    tick(1);
    src[0] = 5'd25;
    for (int k = 0; k < 6; k++) begin
      #11;
      check(24'(outs[0]), 24'(pxi_clk10_i));
    end
    tick(1);
    src[0] = 5'd26;
    #1;
    check(24'(outs[0]), 24'd0);
    tick(1);
    src[0] = 5'd0;
    #1;
    check(24'(outs[0]), 24'd0);
  endtask : t_int

  // One front-panel source to a bus and a star line, realigned
  task automatic t_sync;
    int n;
    tick(1);
    en = 24'h01_8000;
    syn = 24'h01_8000;
    drv_en = ~en;
    drv_val = '0;
    src[16] = 5'd1;
    src[15] = 5'd1;
    tick(10);
    check(outs & en, '0);
    drv_val[1] = 1'b1;
    #1;
    check(outs & en, '0);
    tick(2);
    check(outs & en, '0);
    n = 0;
    while (outs[16] !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    check(outs & en, en);
    check(24'(n > 4), 24'd0);
    drv_val[1] = 1'b0;
    tick(2);
    check(outs & en, en);
    tick(6);
    check(outs & en, '0);
  endtask : t_sync

  initial begin
    en = 24'h55_5555;
    tick(3);
    check(oes, '0);
    nrst_i = 1'b1;
    tick(3);
    check(oes, en);
    t_async(1'b0);
    t_async(1'b1);
    t_int;
    t_sync;
    complete_run;
  end

  initial begin
    #100_000;
    err_count++;
    complete_run;
  end
endmodule : test_trm_matrix
